// >>> dv/vmb_bridge_tb.sv
// Bench for the bridge: registers, VME slave port, module slots, interrupts.
// Assumes the VME master model and an inline module slot responder.
`timescale 1ns/1ps
module vmb_bridge_tb import vmb_pkg::*; ;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:2]  adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] wrd;
  logic [15:0] mrd = '1;
  logic [15:0] mdat = '0;
  logic [15:0] rd;
  logic [15:0] sel = '1;
  logic [3:0]  mack = '1;
  logic [3:0]  sq = '1;
  logic [7:0]  mint = '1;
  logic [40:0] cap = '0;
  logic        doe_q = 1'b1;
  wire  [22:1] maddr;
  wire  [15:0] mwd;
  wire  [1:0]  mbn;
  wire         mwn, doe, dto;
  wire  [31:0] wdo;
  wire  [15:0] vdo, vdi;
  wire  [23:1] va;
  wire  [7:1]  irq;
  wire  [5:0]  am;
  wire  [3:0]  io, id, mem, vec, led;
  wire  [1:0]  ds;
  wire         wack, mclk, dt, iout, asn, wrn, ia, iin;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          waits = 0;
  int          wc = -1;
  int          lat;
  vmb_bridge #(.LED_STRETCH(20)) dut_u (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(wdo), .wb_ack_o(wack), .vme_addr(va), .vme_am(am), .vme_as_n(asn),
    .vme_ds_n(ds), .vme_write_n(wrn), .vme_iack_n(ia), .vme_iackin_n(iin),
    .vme_data_in(vdi), .vme_data_out(vdo), .vme_data_oe_n(doe), .vme_dtack_out(dto),
    .vme_dtack_oe_n(dt), .vme_iackout_n(iout), .vme_irq_oe_n(irq),
    .short_base_jumper(6'h05), .module_clk(mclk), .module_addr(maddr), .module_wdata(mwd),
    .module_rdata(mrd), .module_write_n(mwn), .module_byte_n(mbn), .module_io_select_n(io),
    .module_ident_select_n(id), .module_memory_select_n(mem),
    .module_vector_select_n(vec), .module_ack_n(mack), .module_int_n(mint),
    .access_led(led));
  vmb_vme_master vm_u (.clock(clock), .vme_addr(va), .vme_am(am), .vme_as_n(asn),
    .vme_ds_n(ds), .vme_write_n(wrn), .vme_iack_n(ia), .vme_iackin_n(iin),
    .vme_data_in(vdi), .vme_data_out(vdo), .vme_dtack_oe_n(dt), .vme_iackout_n(iout));
  // Module answers one module clock after select, plus wait states
  always @(posedge mclk) begin
    if (wc == 0) begin
      mack <= sq;
      mrd <= mdat;
    end else begin
      mack <= 4'hF;
      mrd <= ~mdat;
    end
    if ((io & id & mem & vec) != 4'hF) begin
      sq = io & id & mem & vec;
      sel = {io, id, mem, vec};
      cap = {mwd, mwn, mbn, maddr};
      wc = waits;
    end else if (wc >= 0) wc = wc - 1;
  end
  // Data drive state while the acknowledge stands
  always @(posedge clock) if (dt === 1'b0) doe_q <= doe;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    we <= w;
    adr <= a[7:2];
    wdat <= {24'h0, d};
    while (wack !== 1'b1) @(posedge clock);
    wrd = wdo;
    cyc <= 1'b0;
    @(posedge clock);
  endtask : wb
  // Aligned to the module clock so latencies repeat exactly
  task automatic mx(input logic [5:0] m, input logic [23:0] a, input logic [1:0] d,
      input logic iack, input int lim);
    @(posedge mclk);
    vm_u.xfer(m, a, d, 1'b0, 16'h0, iack, lim, rd, lat);
  endtask : mx
  task automatic t_carrier();
    wb(1'b1, REG_LEVEL, 8'h05);
    wb(1'b0, REG_LEVEL, 8'h00);
    chk(wrd, 32'h5);
    wb(1'b0, 8'h3C, 8'h00);
    chk(wrd, 32'h0);
    mx(AM_SHORT_A, 24'h001404, 2'b10, 1'b0, 40);
    chk(rd[7:0], 8'h05);
    chk({doe_q, dto}, 2'b00);
    chk(lat > 15 && lat < 22, 1'b1);
    vm_u.xfer(AM_SHORT_B, 24'h001404, 2'b10, 1'b1, 16'h0006, 1'b0, 40, rd, lat);
    wb(1'b0, REG_LEVEL, 8'h00);
    chk(wrd, 32'h6);
  endtask : t_carrier
  task automatic t_module();
    int l0;
    for (int s = 0; s < 4; s++) begin
      mdat = 16'hC350 + 16'(s);
      mx(AM_SHORT_B, 24'h001602 + 24'(s) * 24'h80, 2'b00, 1'b0, 60);
      chk(rd, mdat);
      chk(sel, {~(4'h1 << s), 12'hFFF});
      chk(cap[21:0], 22'h1);
      chk(led[s], 1'b1);
    end
    l0 = lat;
    chk(l0 > 11 && l0 < 27, 1'b1);
    waits = 1;
    mx(AM_SHORT_B, 24'h001602, 2'b00, 1'b0, 60);
    waits = 0;
    chk(lat - l0, 5);
    repeat (25) @(posedge clock);
    chk(led, 4'h0);
    mdat = 16'h1234;
    mx(AM_SHORT_A, 24'h001546, 2'b00, 1'b0, 60);
    chk(rd, {ID_UPPER, 8'h34});
    chk(sel, 16'hFDFF);
    chk(cap[21:0], 22'h3);
    vm_u.xfer(AM_SHORT_B, 24'h001602, 2'b01, 1'b1, 16'hBEEF, 1'b0, 60, rd, lat);
    chk({cap[40:22], doe_q, lat > 0}, {16'hBEEF, 3'b001, 2'b11});
    chk(cap[21:0], 22'h1);
  endtask : t_module
  task automatic t_memory();
    mx(AM_STD_A, 24'h300010, 2'b00, 1'b0, 40);
    chk(lat, 0);
    mx(6'h09, 24'h001404, 2'b10, 1'b0, 40);
    chk(lat, 0);
    wb(1'b1, REG_MEM_BASE + 8'h0C, 8'h92);
    mdat = 16'h5A3C;
    mx(AM_STD_A, 24'h300010, 2'b00, 1'b0, 60);
    chk(rd, mdat);
    chk(sel, 16'hFF7F);
    chk(cap[21:0], 22'h80008);
    mx(AM_STD_B, 24'h400010, 2'b00, 1'b0, 40);
    chk(lat, 0);
  endtask : t_memory
  task automatic t_irq();
    wb(1'b1, REG_INT_ENABLE, 8'h02);
    wb(1'b1, REG_LEVEL, 8'h03);
    wb(1'b1, REG_CTRL, 8'h01);
    mint <= 8'hFD;
    repeat (8) @(posedge clock);
    chk(irq, 7'h7B);
    mdat = 16'h00A5;
    mx(AM_SHORT_A, 24'h00000A, 2'b00, 1'b1, 30);
    chk({lat == 0, vm_u.iackout_seen}, 2'b11);
    mx(AM_SHORT_A, 24'h000006, 2'b00, 1'b1, 60);
    chk({rd, vm_u.iackout_seen}, {mdat, 1'b0});
    chk(sel, 16'hFFFE);
    chk(irq, 7'h7B);
    wb(1'b1, REG_INT_ENABLE, 8'h03);
    mint <= 8'hFC;
    repeat (4) @(posedge clock);
    mx(AM_SHORT_A, 24'h000006, 2'b00, 1'b1, 60);
    chk(cap[21:0], 22'h0);
    mx(AM_SHORT_A, 24'h000006, 2'b00, 1'b1, 60);
    chk(cap[21:0], 22'h1);
    mint <= 8'hFF;
    // Module must drop its request before the clear, else set wins
    repeat (4) @(posedge clock);
    wb(1'b1, REG_INT_CLEAR, 8'h03);
    repeat (4) @(posedge clock);
    chk(irq, 7'h7F);
  endtask : t_irq
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial forever #12.5 clock = ~clock;
  initial begin
    #(25 * 20000);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_carrier();
    t_module();
    t_memory();
    t_irq();
    end_sim();
  end
endmodule : vmb_bridge_tb

// >>> dv/vmb_vme_master.sv
// VME master and interrupt handler model driving the bridge slave pins.
// Assumes terminated lines: a released pin reads high.
`timescale 1ns/1ps
module vmb_vme_master (
  // Clock
  input  wire logic        clock,
  // Master pins
  output logic      [23:1] vme_addr,
  output logic      [5:0]  vme_am,
  output logic             vme_as_n,
  output logic      [1:0]  vme_ds_n,
  output logic             vme_write_n,
  output logic             vme_iack_n,
  output logic             vme_iackin_n,
  output logic      [15:0] vme_data_in,
  // Slave answers
  input  wire logic [15:0] vme_data_out,
  input  wire logic        vme_dtack_oe_n,
  input  wire logic        vme_iackout_n
);
  logic iackout_seen = 1'b0;
  initial {vme_addr, vme_am, vme_as_n, vme_ds_n, vme_write_n, vme_iack_n, vme_iackin_n,
    vme_data_in} = '1;
  task automatic xfer(input logic [5:0] am, input logic [23:0] a, input logic [1:0] ds,
      input logic wr, input logic [15:0] wd, input logic iack, input int lim,
      output logic [15:0] rd, output int lat);
    lat = 0;
    rd = '1;
    vme_am <= am;
    vme_addr <= a[23:1];
    vme_write_n <= !wr;
    vme_data_in <= wr ? wd : '1;
    vme_iack_n <= !iack;
    vme_as_n <= 1'b0;
    @(posedge clock);
    vme_ds_n <= ds;
    vme_iackin_n <= !iack;
    // Lat 0 means the slave never answered
    for (int n = 1; n <= lim && lat == 0; n++) begin
      @(posedge clock);
      if (vme_dtack_oe_n === 1'b0) begin
        lat = n;
        rd = vme_data_out;
      end
    end
    iackout_seen = vme_iackout_n === 1'b0;
    {vme_addr, vme_am, vme_as_n, vme_ds_n, vme_write_n, vme_iack_n, vme_iackin_n,
      vme_data_in} <= '1;
    for (int n = 0; n < 8 && vme_dtack_oe_n !== 1'b1; n++) @(posedge clock);
    @(posedge clock);
  endtask : xfer
endmodule : vmb_vme_master

// >>> hdl/vmb_bridge.sv
// Bridge from a VME slave port to four mezzanine module slots.
// Assumes VME pins are asynchronous; Wishbone runs on the same clock.
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module vmb_bridge import vmb_pkg::*; #(
  parameter int unsigned LED_STRETCH = LED_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Wishbone register port
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // VME slave pins
  input  wire logic [23:1] vme_addr,
  input  wire logic [5:0]  vme_am,
  input  wire logic        vme_as_n,
  input  wire logic [1:0]  vme_ds_n,
  input  wire logic        vme_write_n,
  input  wire logic        vme_iack_n,
  input  wire logic        vme_iackin_n,
  input  wire logic [15:0] vme_data_in,
  output logic      [15:0] vme_data_out,
  output logic             vme_data_oe_n,
  output logic             vme_dtack_out,
  output logic             vme_dtack_oe_n,
  output logic             vme_iackout_n,
  output logic      [7:1]  vme_irq_oe_n,
  input  wire logic [15:10] short_base_jumper,
  // Module slots
  output logic             module_clk,
  output logic      [22:1] module_addr,
  output logic      [15:0] module_wdata,
  input  wire logic [15:0] module_rdata,
  output logic             module_write_n,
  output logic      [1:0]  module_byte_n,
  output logic      [3:0]  module_io_select_n,
  output logic      [3:0]  module_ident_select_n,
  output logic      [3:0]  module_memory_select_n,
  output logic      [3:0]  module_vector_select_n,
  input  wire logic [3:0]  module_ack_n,
  input  wire logic [7:0]  module_int_n,
  output logic      [3:0]  access_led
);
  localparam int SYNC_W = 85;
  localparam int DIV_W  = $clog2(MODCLK_DIV);
  localparam int CW_LO  = CARRIER_WAIT;
  localparam int CW_HI  = CARRIER_WAIT + 2;

  if (LED_STRETCH < 2 || MODCLK_DIV < 2) begin : g_bad
    $error("vmb_bridge: unusable timing parameters");
  end

  // Two-stage synchroniser for every pin input
  logic [SYNC_W-1:0] sync_meta, sync_q;
  logic [23:1] s_addr;
  logic [5:0]  s_am;
  logic        s_as_n, s_write_n, s_iack_n, s_iackin_n;
  logic [1:0]  s_ds_n;
  logic [15:0] s_data, s_rdata;
  logic [15:10] s_jump;
  logic [3:0]  s_ack_n;
  logic [7:0]  s_int_n;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_meta <= '1;
      sync_q    <= '1;
    end else begin
      sync_meta <= {vme_addr, vme_am, vme_as_n, vme_ds_n, vme_write_n, vme_iack_n,
                    vme_iackin_n, vme_data_in, short_base_jumper, module_rdata,
                    module_ack_n, module_int_n};
      sync_q    <= sync_meta;
    end
  end
  assign {s_addr, s_am, s_as_n, s_ds_n, s_write_n, s_iack_n, s_iackin_n, s_data,
          s_jump, s_rdata, s_ack_n, s_int_n} = sync_q;

  // Carrier registers
  logic [7:0] ctrl, int_en, pending;
  logic [2:0] level;
  logic [7:0] mem_cfg [SLOTS];

  function automatic logic [7:0] reg_read(input logic [7:0] off);
    logic [7:0] v;
    v = 8'h00;
    case (off)
      REG_CTRL:        v = ctrl;
      REG_LEVEL:       v = {5'h00, level};
      REG_INT_ENABLE:  v = int_en;
      REG_INT_PENDING: v = pending;
      default: begin
        if (off[7:4] == REG_MEM_BASE[7:4] && off[1:0] == 2'h0) v = mem_cfg[off[3:2]];
      end
    endcase
    return v;
  endfunction : reg_read

  // window of size 1..8 MB at base
  function automatic logic mem_hit(input logic [7:0] cfg, input logic [3:0] mb);
    logic [4:0] lim;
    lim = 5'(cfg[3:0]) + 5'(cfg[6:4]) + 5'h01;
    return cfg[MEM_EN_BIT] && (mb >= cfg[3:0]) && (5'(mb) < lim);
  endfunction : mem_hit

  // Module clock divider, 8 MHz from 40 MHz
  logic [DIV_W-1:0] div, next_div;
  logic rise_tick, fall_tick;
  assign next_div  = (div == DIV_W'(MODCLK_DIV - 1)) ? '0 : div + 1'b1;
  assign rise_tick = (div == DIV_W'(MODCLK_DIV - 1));
  assign fall_tick = (div == DIV_W'(MODCLK_HIGH - 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // Start one short of wrap so the first module clock pulse is full width
      div        <= DIV_W'(MODCLK_DIV - 1);
      module_clk <= 1'b0;
    end else begin
      div        <= next_div;
      module_clk <= (next_div < DIV_W'(MODCLK_HIGH));
    end
  end

  // Address decode of the strobed cycle
  vmb_state_type state;
  vmb_space_type space, dec_space;
  logic [1:0]  slot, dec_slot;
  logic [22:1] dec_addr;
  logic        short_am, std_am, short_hit, std_hit, irq_active, ours;
  logic        strobe, dec_module, dec_carrier;
  logic [2:0]  grant;
  logic        wb_wr, vme_wr, wr_go;
  logic [7:0]  wr_off, wr_val, clr_vec;
  logic [$clog2(CW_HI+1)-1:0] wait_cnt;
  logic [3:0]  led_trig;

  assign strobe     = !s_as_n && (s_ds_n != 2'h3);
  assign short_am   = (s_am == AM_SHORT_A) || (s_am == AM_SHORT_B);
  assign std_am     = (s_am == AM_STD_A) || (s_am == AM_STD_B);
  assign irq_active = ctrl[CTRL_GLOBAL_IE] && (pending != 8'h00) && (level != 3'h0);
  assign ours       = irq_active && (s_addr[3:1] == level);
  assign short_hit  = s_iack_n && short_am && (s_addr[15:10] == s_jump);

  always_comb begin
    std_hit     = 1'b0;
    dec_slot    = 2'h0;
    dec_space   = SP_IO;
    dec_addr    = '0;
    dec_carrier = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (s_iack_n && std_am && mem_hit(mem_cfg[i], s_addr[23:20]) && !std_hit) begin
        std_hit  = 1'b1;
        dec_slot = 2'(i);
      end
    end
    if (!s_iack_n) begin
      dec_space = SP_VEC;
      dec_slot  = grant[2:1];
      dec_addr  = {21'h0, grant[0]};
    end else if (std_hit) begin
      dec_space = SP_MEM;
      dec_addr  = {s_addr[22:20] - mem_cfg[dec_slot][2:0], s_addr[19:1]};
    end else if (s_addr[9:8] == RGN_CARRIER) begin
      dec_carrier = 1'b1;
    end else if (s_addr[9:8] == RGN_IDENT) begin
      dec_space = SP_ID;
      dec_slot  = s_addr[7:6];
      dec_addr  = {17'h0, s_addr[5:1]};
    end else begin
      dec_slot  = s_addr[8:7];
      dec_addr  = {16'h0, s_addr[6:1]};
    end
    dec_module = (!s_iack_n && !s_iackin_n && ours) || std_hit || (short_hit && !dec_carrier);
  end

  // Register writes, Wishbone first
  assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign vme_wr  = (state == ST_CARRIER) && (wait_cnt == CW_LO) && !s_write_n && !wb_wr;
  assign wr_go   = wb_wr || vme_wr;
  assign wr_off  = wb_wr ? {wb_adr_i, 2'h0} : {s_addr[7:1], 1'b0};
  assign wr_val  = wb_wr ? wb_dat_i[7:0] : s_data[7:0];
  assign clr_vec = (wr_go && wr_off == REG_INT_CLEAR) ? wr_val : 8'h00;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl   <= 8'h00;
      level  <= 3'h0;
      int_en <= 8'h00;
      for (int i = 0; i < SLOTS; i++) mem_cfg[i] <= 8'h00;
    end else if (wr_go) begin
      case (wr_off)
        REG_CTRL:       ctrl   <= wr_val;
        REG_LEVEL:      level  <= wr_val[2:0];
        REG_INT_ENABLE: int_en <= wr_val;
        default: begin
          if (wr_off[7:4] == REG_MEM_BASE[7:4] && wr_off[1:0] == 2'h0)
            mem_cfg[wr_off[3:2]] <= wr_val;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) pending <= 8'h00;
    else     pending <= (pending & ~clr_vec) | (~s_int_n & int_en);
  end

  // Wishbone slave, one wait cycle; unmapped offsets read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= {24'h00_0000, reg_read({wb_adr_i, 2'h0})};
    end
  end

  // one line on the chosen level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      vme_irq_oe_n <= '1;
    end else begin
      for (int k = 1; k < 8; k++) vme_irq_oe_n[k] <= !(irq_active && level == 3'(k));
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) vme_iackout_n <= 1'b1;
    else     vme_iackout_n <= !(strobe && !s_iack_n && !s_iackin_n && !ours
                                && state == ST_IDLE);
  end

  vmb_irq_arbiter #(.N(IRQ_SOURCES)) u_arb (
    .clock   (clock),
    .rst     (rst),
    .req     (pending),
    .advance (state == ST_WAIT && rise_tick && !s_ack_n[slot] && space == SP_VEC),
    .grant   (grant)
  );

  // Transfer sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state          <= ST_IDLE;
      space          <= SP_IO;
      slot           <= 2'h0;
      wait_cnt       <= '0;
      led_trig       <= 4'h0;
      vme_data_out   <= 16'hFFFF;
      vme_data_oe_n  <= 1'b1;
      vme_dtack_out  <= 1'b0;
      vme_dtack_oe_n <= 1'b1;
      module_addr    <= '0;
      module_wdata   <= 16'h0000;
      module_write_n <= 1'b1;
      module_byte_n  <= 2'h3;
      module_io_select_n     <= 4'hF;
      module_ident_select_n  <= 4'hF;
      module_memory_select_n <= 4'hF;
      module_vector_select_n <= 4'hF;
    end else begin
      led_trig <= 4'h0;
      case (state)
        ST_IDLE: begin
          // start only on a decoded hit
          if (strobe && short_hit && dec_carrier) begin
            wait_cnt <= '0;
            state    <= ST_CARRIER;
          end else if (strobe && dec_module) begin
            space          <= dec_space;
            slot           <= dec_slot;
            module_addr    <= dec_addr;
            module_wdata   <= s_data;
            module_write_n <= s_write_n;
            module_byte_n  <= s_ds_n;
            state          <= ST_SETUP;
          end
        end
        ST_CARRIER: begin
          if (wait_cnt != CW_LO) begin
            wait_cnt <= wait_cnt + 1'b1;
          end else if (vme_wr || s_write_n) begin
            vme_data_out   <= {8'h00, reg_read({s_addr[7:1], 1'b0})};
            vme_data_oe_n  <= !s_write_n;
            vme_dtack_oe_n <= 1'b0;
            state          <= ST_ACKED;
          end
        end
        ST_SETUP: begin
          if (fall_tick) begin
            module_io_select_n[slot]     <= !(space == SP_IO);
            module_ident_select_n[slot]  <= !(space == SP_ID);
            module_memory_select_n[slot] <= !(space == SP_MEM);
            module_vector_select_n[slot] <= !(space == SP_VEC);
            state                        <= ST_SELECT;
          end
        end
        ST_SELECT: begin
          if (fall_tick) begin
            module_io_select_n     <= 4'hF;
            module_ident_select_n  <= 4'hF;
            module_memory_select_n <= 4'hF;
            module_vector_select_n <= 4'hF;
            state                  <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (rise_tick && !s_ack_n[slot]) begin
            vme_data_out   <= (space == SP_ID) ? {ID_UPPER, s_rdata[7:0]} : s_rdata;
            vme_data_oe_n  <= !module_write_n;
            vme_dtack_oe_n <= 1'b0;
            led_trig[slot] <= 1'b1;
            state          <= ST_ACKED;
          end
        end
        ST_ACKED: begin
          if (s_ds_n == 2'h3 || s_as_n) begin
            vme_data_oe_n  <= 1'b1;
            vme_dtack_oe_n <= 1'b1;
            module_write_n <= 1'b1;
            module_byte_n  <= 2'h3;
            state          <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  for (genvar g = 0; g < SLOTS; g++) begin : g_led
    vmb_led_stretch #(.CYCLES(LED_STRETCH)) u_led (
      .clock   (clock),
      .rst     (rst),
      .trigger (led_trig[g]),
      .led     (access_led[g])
    );
  end

  logic sel_any;
  assign sel_any = (module_io_select_n & module_ident_select_n & module_memory_select_n
                    & module_vector_select_n) != 4'hF;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  AST_SEL_ONE_CYCLE: assert property ($rose(sel_any) |-> sel_any [*5] ##1 !sel_any)
    else $error("select not held one module clock");
  AST_NO_EARLY_DTACK: assert property ((state == ST_WAIT && s_ack_n[slot]) |=> vme_dtack_oe_n)
    else $error("acknowledge before module ack");
  AST_FOREIGN_IGNORED: assert property ((state == ST_IDLE && strobe && s_iack_n
    && !short_am && !std_am) |=> state == ST_IDLE && vme_dtack_oe_n)
    else $error("foreign modifier answered");
  AST_MEM_GATED: assert property ((state == ST_IDLE && strobe && std_am && s_iack_n
    && !std_hit) |=> state == ST_IDLE) else $error("memory access while disabled");
  AST_CARRIER_TIME: assert property ($rose(state == ST_CARRIER) && !s_write_n
    |-> ##[CW_LO:CW_HI] !vme_dtack_oe_n) else $error("carrier access time wrong");
  AST_ID_UPPER: assert property ((!vme_dtack_oe_n && !vme_data_oe_n && space == SP_ID
    && state == ST_ACKED) |-> vme_data_out[15:8] == ID_UPPER) else $error("ident upper byte");
  AST_RELEASE_HOLD: assert property (1'b1 |=> ($past(pending & ~clr_vec) & ~pending) == 8'h00)
    else $error("request dropped without clear");
  AST_IACK_PASS: assert property ((!s_iack_n && !s_iackin_n && strobe && !ours
    && state == ST_IDLE) |=> !vme_iackout_n) else $error("acknowledge chain not passed");
  AST_IRQ_LEVEL: assert property ((vme_irq_oe_n != 7'h7F) |->
    vme_irq_oe_n == ~(7'h01 << ($past(level) - 3'h1))) else $error("wrong request level");
  AST_MODCLK: assert property ($rose(module_clk) |-> ##5 $rose(module_clk))
    else $error("module clock not 8 MHz");

  COV_CARRIER: cover property ($rose(state == ST_CARRIER) ##[1:40] state == ST_ACKED);
  COV_WAIT_STATE: cover property (state == ST_WAIT && rise_tick && s_ack_n[slot]
    ##[1:20] state == ST_ACKED);
  COV_VECTOR: cover property (state == ST_ACKED && space == SP_VEC);
  COV_MEMORY: cover property (state == ST_ACKED && space == SP_MEM);
endmodule : vmb_bridge

// >>> hdl/vmb_irq_arbiter.sv
// Round robin choice among pending module interrupt requests.
// Assumes requests are steady while a vector cycle runs.
`timescale 1ns/1ps
module vmb_irq_arbiter import vmb_pkg::*; #(
  parameter int N = IRQ_SOURCES
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Requests and grant
  input  wire logic [N-1:0]         req,
  input  wire logic                 advance,
  output logic      [$clog2(N)-1:0] grant
);
  logic [$clog2(N)-1:0] last;

  if (N < 2) begin : g_bad
    $error("vmb_irq_arbiter needs at least two sources");
  end

  always_comb begin
    int idx;
    logic found;
    idx = 0;
    found = 1'b0;
    grant = '0;
    for (int i = 1; i <= N; i++) begin
      idx = (int'(last) + i) % N;
      if (!found && req[idx]) begin
        found = 1'b1;
        grant = ($clog2(N))'(idx);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last <= ($clog2(N))'(N - 1);
    end else if (advance) begin
      last <= grant;
    end
  end
endmodule : vmb_irq_arbiter

// >>> hdl/vmb_led_stretch.sv
// Pulse stretcher for one slot's access indicator.
// Assumes a one-cycle trigger; a new trigger restarts the count.
`timescale 1ns/1ps
module vmb_led_stretch import vmb_pkg::*; #(
  parameter int unsigned CYCLES = LED_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Trigger and lamp
  input  wire logic trigger,
  output logic      led
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count;

  if (CYCLES < 2) begin : g_bad
    $error("vmb_led_stretch needs at least two cycles");
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
      led   <= 1'b0;
    end else if (trigger) begin
      count <= W'(CYCLES);
      led   <= 1'b1;
    end else if (count != '0) begin
      count <= count - 1'b1;
      led   <= (count != W'(1));
    end
  end

  AST_LED_ON: assert property (@(posedge clock) disable iff (rst)
    trigger |=> led [*8]) else $error("indicator not lit after transfer");
endmodule : vmb_led_stretch

// >>> hdl/vmb_pkg.sv
// Constants, register map and state codes of the VME to mezzanine bridge.
// Assumes a 40 MHz system clock; the 8 MHz module clock is derived from it.
// Function
// - Slave for A24/A16 addressing, D16 and D08 even/odd, incl. read-modify-write.
// - Carrier and zero-wait module accesses finish about 450 ns after strobe.
// - Each module wait state adds one 125 ns module clock period.
// - Short I/O window is 1 KB, its base set by jumpers.
// - Short I/O accepted with modifier 29H or 2DH.
// - Standard space 39H/3DH accepted only when module memory is enabled.
// - Memory base and size per module programmable, 1 MB to 8 MB.
// - Interrupt on programmable level 1 to 7, two requests per module.
// - Acknowledge vector comes from the module, D16 or odd byte.
// - Request stays until software writes the clear register.
// - Four module slots, no 32-bit module data path.
// - Module I/O space: A16, D16 or D08, 128 bytes per module.
// - Identification space: 32 odd-addressed bytes per module.
// - Identification read as D16 returns upper byte all ones.
// - Module memory: A24, D16 or D08, 1 MB to 8 MB.
// - Module cycles run at 8 MHz only.
// - Select held one module clock; acknowledge sampled a cycle later.
// - Acknowledge daisy chain consumed when the level matches an active request, passed otherwise.
// - Pending requests served round robin, last served lowest.
// - Each acknowledged module transfer lights its slot indicator 0.125 s.
package vmb_pkg;
  localparam int CLK_MHZ       = 40;
  localparam int ACCESS_NS     = 450;
  localparam int MODCLK_NS     = 125;
  localparam int SYNC_STAGES   = 2;
  localparam int MODCLK_DIV    = MODCLK_NS * CLK_MHZ / 1000;
  localparam int MODCLK_HIGH   = MODCLK_DIV / 2;
  localparam int CARRIER_WAIT  = ACCESS_NS * CLK_MHZ / 1000 - SYNC_STAGES - 1;
  localparam int LED_US        = 125000;
  localparam int LED_CYCLES    = LED_US * CLK_MHZ;
  localparam int SLOTS         = 4;
  localparam int IRQ_SOURCES   = 2 * SLOTS;

  localparam logic [5:0] AM_SHORT_A = 6'h29;
  localparam logic [5:0] AM_SHORT_B = 6'h2D;
  localparam logic [5:0] AM_STD_A   = 6'h39;
  localparam logic [5:0] AM_STD_B   = 6'h3D;

  // Short window regions, selected by address bits 9:8
  localparam logic [1:0] RGN_CARRIER = 2'h0;
  localparam logic [1:0] RGN_IDENT   = 2'h1;

  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_LEVEL       = 8'h04;
  localparam logic [7:0] REG_INT_ENABLE  = 8'h08;
  localparam logic [7:0] REG_INT_PENDING = 8'h0C;
  localparam logic [7:0] REG_INT_CLEAR   = 8'h10;
  localparam logic [7:0] REG_MEM_BASE    = 8'h20;
  localparam int         CTRL_GLOBAL_IE  = 0;
  localparam int         MEM_EN_BIT      = 7;
  localparam logic [7:0] ID_UPPER        = 8'hFF;

  typedef enum logic [1:0] {SP_IO = 2'h0, SP_ID = 2'h1, SP_MEM = 2'h2, SP_VEC = 2'h3} vmb_space_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_SETUP = 3'h1, ST_SELECT = 3'h3, ST_WAIT = 3'h2,
    ST_ACKED = 3'h6, ST_CARRIER = 3'h4
  } vmb_state_type;
endpackage : vmb_pkg
